/* cst_code_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module cst_code_mem
	import cst_pkg::*;
(
	// clock
	input  wire logic        i_clk,
	// fetch side of the core
	input  wire cst_mem_type i_mem,
	output logic [7:0]       o_data
);
	logic [7:0] last;

	always_ff @(posedge i_clk) begin
		last <= o_data;
	end
	// one pattern for rom and external space, any 16-bit address
	// bus released between strobes: value keeps changing, never stale
	assign o_data = i_mem.code_rd ? i_mem.code_addr[7:0] ^
		i_mem.code_addr[15:8] ^ 8'h5a : ~last;
endmodule
`default_nettype wire

/* cst_core.sv */
`timescale 1ns/10ps
`default_nettype none

// How it works
// - status word sits at D0: carry, nibble carry, f0, bank hi/lo, ov, f1, parity
// - bank bits pick register bytes 00-07, 08-0F, 10-17 or 18-1F
// - parity flag refreshed after every instruction, odd ones give one
// - arithmetic writes carry and signed overflow results
// - BCD operations write the nibble carry flag
// - helper register is mul/div operand and result, else scratch
// - stack pointer pre-increments on push, post-decrements on pop
// - stack pointer resets to 07, software reads and writes it
// - machine cycle is six states, each split in two phases
// - flag arithmetic in phase 1, register transfers in phase 2
// - address latch strobe at S1P2-S2P1, and at S4P2-S5P1 except in external move second cycle
// - opcode latched at S1P2, second byte at S4, done at S6P2
// - one-byte instructions discard the S4 fetch, pc stays
// - mul/div take four cycles, others one or two
// - two code fetches per machine cycle normally
// - external data move second cycle skips both fetches, strobes data
// - fetch select high: below 4000 from internal rom, else external
// - fetch select low: every fetch goes external
// - 16-bit code and data address, 8-bit internal address
// - upper 128 bytes: indirect to ram, direct to function registers
// - opcode picks bank register; first two serve as pointers
module cst_core
	import cst_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output var  logic [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// decoder and datapath
	input  wire cst_dec_type i_dec,
	input  wire logic [7:0]  i_acc,
	// memory side
	input  wire logic        i_ext_fetch_select,
	input  wire logic [7:0]  i_code_data,
	output cst_mem_type      o_mem,
	// core state
	output var  logic [7:0]  o_psw,
	output var  logic [7:0]  o_sp,
	output var  logic [7:0]  o_b,
	output var  logic [7:0]  o_ir,
	output var  logic [7:0]  o_op2,
	output logic [15:0]      o_pc,
	output logic [2:0]       o_state_num,
	output logic             o_phase2,
	output logic             o_instr_done,
	// internal data addressing
	output logic [7:0]       o_reg_addr,
	output logic [7:0]       o_ptr_addr,
	output logic [7:0]       o_stack_addr,
	output logic             o_sfr_sel
);

	function automatic logic ale_on(input logic [3:0] ph, input logic xm2);
		ale_on = (ph == PH_S1P2) || (ph == PH_S2P1)
			|| (!xm2 && ((ph == PH_S4P2) || (ph == PH_S5P1)));
	endfunction

	function automatic logic fetch_on(input logic [3:0] ph, input logic xm2);
		fetch_on = !xm2 && ((ph == PH_S1P1) || (ph == PH_S1P2)
			|| (ph == PH_S4P1) || (ph == PH_S4P2));
	endfunction

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == OFS_PSW) || (a == OFS_SP) || (a == OFS_B)
			|| (a == OFS_TIMING);
	endfunction

	logic [3:0]  phase;
	cst_cyc_type cyc;
	logic [15:0] pc;
	logic        ea_s1, ea_s2, ea_s3, ext_sel;
	logic        xm2, last_cyc, end_alu, end_xfer, stack_step;
	logic        wr_en;
	logic        code_int;

	assign xm2 = (cyc == CYC_2) && (i_dec.kind == KIND_XMOVE);
	always_comb begin
		case (cyc)
		CYC_1: last_cyc = (i_dec.kind == KIND_NORMAL) && !i_dec.two_cycle;
		CYC_2: last_cyc = (i_dec.kind != KIND_MULDIV);
		CYC_3: last_cyc = 1'b0;
		CYC_4: last_cyc = 1'b1;
		default: last_cyc = 1'b1;
		endcase
	end
	assign end_alu    = last_cyc && (phase == PH_S6P1);
	assign end_xfer   = last_cyc && (phase == PH_S6P2);
	assign stack_step = (phase == PH_S6P2) && (i_dec.push ^ i_dec.pop);
	assign wr_en = i_psel && i_penable && i_pwrite;

	// phase sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			phase <= PH_S1P1;
		end else if (phase == PH_S6P2) begin
			phase <= PH_S1P1;
		end else begin
			phase <= phase + 4'h1;
		end
	end

	// machine cycle within the instruction
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cyc <= CYC_1;
		end else if (phase == PH_S6P2) begin
			case (cyc)
			CYC_1: cyc <= last_cyc ? CYC_1 : CYC_2;
			CYC_2: cyc <= last_cyc ? CYC_1 : CYC_3;
			CYC_3: cyc <= CYC_4;
			CYC_4: cyc <= CYC_1;
			default: cyc <= CYC_1;
			endcase
		end
	end

	// fetch select pin; counted once two later stages agree
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ea_s1 <= 1'b0;
			ea_s2 <= 1'b0;
			ea_s3 <= 1'b0;
			ext_sel <= 1'b0;
		end else begin
			ea_s1 <= i_ext_fetch_select;
			ea_s2 <= ea_s1;
			ea_s3 <= ea_s2;
			if (ea_s2 == ea_s3) begin
				ext_sel <= ea_s3;
			end
		end
	end

	// opcode, second byte and program counter
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pc <= PC_RESET;
			o_ir <= 8'h00;
			o_op2 <= 8'h00;
		end else if (end_xfer && i_dec.pc_load) begin
			pc <= i_dec.pc_val;
		end else if (cyc == CYC_1 && phase == PH_S1P2) begin
			o_ir <= i_code_data;
			pc <= pc + 16'h0001;
		end else if (cyc == CYC_1 && phase == PH_S4P2) begin
			if (i_dec.two_byte) begin
				o_op2 <= i_code_data;
				pc <= pc + 16'h0001;
			end
		end
	end

	// code and external data bus strobes
	assign code_int = ext_sel && (pc <= ROM_TOP);
	always_comb begin
		o_mem.code_addr = pc;
		o_mem.code_rd = fetch_on(phase, xm2);
		o_mem.code_int = code_int;
		o_mem.ale = ale_on(phase, xm2);
		o_mem.xdata_stb = xm2 && (phase >= PH_S2P2)
			&& (phase <= PH_S5P2);
	end

	// status word: software write first, hardware update wins
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_psw <= PSW_RESET;
		end else begin
			if (wr_en && i_paddr == OFS_PSW) begin
				o_psw[7:1] <= i_pwdata[7:1];
			end
			if (end_alu) begin
				if (i_dec.cy_we) begin
					o_psw[PSW_CY] <= i_dec.cy;
				end
				if (i_dec.ov_we) begin
					o_psw[PSW_OV] <= i_dec.ov;
				end
				if (i_dec.ac_we) begin
					o_psw[PSW_AC] <= i_dec.ac;
				end
			end
			if (end_xfer) begin
				o_psw[PSW_P] <= ^i_acc;
			end
		end
	end

	// stack pointer
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_sp <= SP_RESET;
		end else if (stack_step) begin
			o_sp <= i_dec.push ? o_sp + 8'h01 : o_sp - 8'h01;
		end else if (wr_en && i_paddr == OFS_SP) begin
			o_sp <= i_pwdata[7:0];
		end
	end

	// helper register
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_b <= B_RESET;
		end else if (end_xfer && i_dec.b_we
			&& i_dec.kind == KIND_MULDIV) begin
			o_b <= i_dec.b_val;
		end else if (wr_en && i_paddr == OFS_B) begin
			o_b <= i_pwdata[7:0];
		end
	end

	// push writes above the top, pop reads the top
	assign o_stack_addr = i_dec.push ? o_sp + 8'h01 : o_sp;
	assign o_reg_addr = {3'h0, o_psw[PSW_RS1], o_psw[PSW_RS0],
		i_dec.reg_idx};
	assign o_ptr_addr = {3'h0, o_psw[PSW_RS1], o_psw[PSW_RS0], 2'h0,
		i_dec.reg_idx[0]};
	// the shared upper half goes by addressing mode
	assign o_sfr_sel = !i_dec.indirect && i_dec.dir_addr[7];
	assign o_pc = pc;
	assign o_state_num = 3'(phase[3:1] + 3'h1);
	assign o_phase2 = phase[0];
	assign o_instr_done = end_xfer;

	// bus read data is captured in setup so it comes from a flop
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			case (i_paddr)
			OFS_PSW:    o_prdata <= {24'h00_0000, o_psw};
			OFS_SP:     o_prdata <= {24'h00_0000, o_sp};
			OFS_B:      o_prdata <= {24'h00_0000, o_b};
			OFS_TIMING: o_prdata <= {22'h00_0000, ext_sel, code_int,
				cyc, phase};
			default:    o_prdata <= 32'h0000_0000;
			endcase
		end
	end
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !reg_hit(i_paddr);

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_psw_reset: assert property ($rose(i_rstn) |-> o_psw == PSW_RESET
		&& o_sp == SP_RESET)
		else $error("status word or stack pointer wrong after reset");
	a_ale_pulse: assert property ($rose(o_mem.ale) |-> (phase == PH_S1P2
		|| phase == PH_S4P2) ##1 o_mem.ale ##1 !o_mem.ale)
		else $error("address latch strobe out of place");
	a_cycle_len: assert property (phase == PH_S6P2 |=> phase == PH_S1P1
		##11 phase == PH_S6P2)
		else $error("machine cycle is not twelve phases");
	a_opcode_latch: assert property (cyc == CYC_1 && phase == PH_S1P2
		|=> o_ir == $past(i_code_data) && pc == $past(pc) + 16'h0001)
		else $error("opcode not latched at S1P2");
	a_discard_fetch: assert property (cyc == CYC_1 && phase == PH_S4P2
		&& !i_dec.two_byte && !end_xfer |=> pc == $past(pc))
		else $error("pc moved on discarded fetch");
	a_parity_upd: assert property (end_xfer |=> o_psw[PSW_P]
		== ^$past(i_acc))
		else $error("parity flag not refreshed");
	a_push_inc: assert property (stack_step && i_dec.push
		|=> o_sp == $past(o_sp) + 8'h01)
		else $error("stack pointer not incremented on push");
	a_pop_dec: assert property (stack_step && i_dec.pop
		|=> o_sp == $past(o_sp) - 8'h01)
		else $error("stack pointer not decremented on pop");
	a_rom_region: assert property (o_mem.code_rd && o_mem.code_int
		|-> ext_sel && o_mem.code_addr <= ROM_TOP)
		else $error("internal fetch outside rom window");
	a_ext_only: assert property (o_mem.code_rd && !ext_sel
		|-> !o_mem.code_int)
		else $error("internal fetch with select low");
	a_xmove_nofetch: assert property (xm2 |-> !o_mem.code_rd)
		else $error("code fetch in external move second cycle");
	a_muldiv_len: assert property (end_xfer && i_dec.kind == KIND_MULDIV
		|-> cyc == CYC_4)
		else $error("mul/div not four cycles");
	a_bank_addr: assert property (o_reg_addr[7:3]
		== {3'h0, o_psw[PSW_RS1:PSW_RS0]})
		else $error("register address ignores bank");
	a_ale_second: assert property (
		phase == PH_S4P2 && !xm2 |-> o_mem.ale)
		else $error("second address latch strobe missing");
	a_fetch_first: assert property (
		phase == PH_S1P1 && !xm2 |-> o_mem.code_rd)
		else $error("opcode fetch strobe missing");
	a_xstb_window: assert property (
		o_mem.xdata_stb |-> xm2 && !o_mem.code_rd)
		else $error("data strobe outside external move");
	a_state_range: assert property (
		o_state_num >= 3'h1 && o_state_num <= 3'h6)
		else $error("state number out of range");
	a_flag_phase: assert property (
		end_alu |-> phase == PH_S6P1 && !o_phase2)
		else $error("flag update outside phase one");
	a_carry_upd: assert property (
		end_alu && i_dec.cy_we |=> o_psw[PSW_CY] == $past(i_dec.cy))
		else $error("carry flag not written");
	a_ovf_upd: assert property (
		end_alu && i_dec.ov_we |=> o_psw[PSW_OV] == $past(i_dec.ov))
		else $error("overflow flag not written");
	a_nibble_upd: assert property (
		end_alu && i_dec.ac_we |=> o_psw[PSW_AC] == $past(i_dec.ac))
		else $error("nibble carry flag not written");
	a_helper_load: assert property (
		end_xfer && i_dec.b_we && i_dec.kind == KIND_MULDIV
		|=> o_b == $past(i_dec.b_val))
		else $error("helper register not loaded by mul/div");
	a_ptr_addr: assert property (
		o_ptr_addr == {o_reg_addr[7:3], 2'h0, i_dec.reg_idx[0]})
		else $error("pointer register outside active bank");
	a_sfr_route: assert property (
		i_dec.indirect |-> !o_sfr_sel)
		else $error("indirect access routed to function registers");
	a_sp_write: assert property (
		wr_en && i_paddr == OFS_SP && !stack_step
		|=> o_sp == $past(i_pwdata[7:0]))
		else $error("stack pointer write lost");
	a_user_flags: assert property (
		wr_en && i_paddr == OFS_PSW
		|=> o_psw[PSW_F0] == $past(i_pwdata[PSW_F0])
		&& o_psw[PSW_F1] == $past(i_pwdata[PSW_F1]))
		else $error("user flag write lost");
	a_one_cycle: assert property (
		end_xfer && i_dec.kind == KIND_NORMAL && !i_dec.two_cycle
		|-> cyc == CYC_1)
		else $error("one-cycle instruction ran long");

endmodule

`default_nettype wire

/* cst_pkg.sv */
package cst_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_PSW    = 8'hD0;
	localparam logic [7:0] OFS_SP     = 8'hD4;
	localparam logic [7:0] OFS_B      = 8'hD8;
	localparam logic [7:0] OFS_TIMING = 8'hDC;

	// program_status_word bit positions
	localparam int PSW_CY = 7;
	localparam int PSW_AC = 6;
	localparam int PSW_F0 = 5;
	localparam int PSW_RS1 = 4;
	localparam int PSW_RS0 = 3;
	localparam int PSW_OV = 2;
	localparam int PSW_F1 = 1;
	localparam int PSW_P  = 0;

	// reset values
	localparam logic [7:0]  PSW_RESET = 8'h00;
	localparam logic [7:0]  SP_RESET  = 8'h07;
	localparam logic [7:0]  B_RESET   = 8'h00;
	localparam logic [15:0] PC_RESET  = 16'h0000;

	// phase index = (state-1)*2 + (phase-1), one i_clk per phase
	localparam logic [3:0] PH_S1P1 = 4'h0;
	localparam logic [3:0] PH_S1P2 = 4'h1;
	localparam logic [3:0] PH_S2P1 = 4'h2;
	localparam logic [3:0] PH_S2P2 = 4'h3;
	localparam logic [3:0] PH_S4P1 = 4'h6;
	localparam logic [3:0] PH_S4P2 = 4'h7;
	localparam logic [3:0] PH_S5P1 = 4'h8;
	localparam logic [3:0] PH_S5P2 = 4'h9;
	localparam logic [3:0] PH_S6P1 = 4'hA;
	localparam logic [3:0] PH_S6P2 = 4'hB;

	// internal code memory top (16 Kbyte)
	localparam logic [15:0] ROM_TOP = 16'h3FFF;

	// instruction class from the decoder
	localparam logic [1:0] KIND_NORMAL = 2'h0;
	localparam logic [1:0] KIND_XMOVE  = 2'h1;
	localparam logic [1:0] KIND_MULDIV = 2'h2;

	typedef enum logic [3:0] {
		CYC_1 = 4'b0001,
		CYC_2 = 4'b0010,
		CYC_3 = 4'b0100,
		CYC_4 = 4'b1000
	} cst_cyc_type;

	typedef struct packed {
		logic [1:0]  kind;
		logic        two_byte;
		logic        two_cycle;
		logic        cy_we;
		logic        cy;
		logic        ac_we;
		logic        ac;
		logic        ov_we;
		logic        ov;
		logic        push;
		logic        pop;
		logic        b_we;
		logic [7:0]  b_val;
		logic        pc_load;
		logic [15:0] pc_val;
		logic [2:0]  reg_idx;
		logic        indirect;
		logic [7:0]  dir_addr;
	} cst_dec_type;

	typedef struct packed {
		logic [15:0] code_addr;
		logic        code_rd;
		logic        code_int;
		logic        ale;
		logic        xdata_stb;
	} cst_mem_type;

endpackage

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import cst_pkg::*;
;
	logic        i_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0;
	logic        i_pwrite = 0, fsel = 1;
	logic [7:0]  i_paddr = 0, i_acc = 0, epsw, esp, eb, cdat;
	logic [31:0] i_pwdata = 0, o_prdata;
	logic [15:0] epc, o_pc;
	logic        o_pready, o_pslverr, o_phase2, o_instr_done, o_sfr_sel;
	logic [7:0]  o_psw, o_sp, o_b, o_ir, o_op2, o_reg_addr;
	logic [7:0]  o_ptr_addr, o_stack_addr;
	logic [2:0]  o_state_num;
	cst_dec_type i_dec;
	cst_mem_type o_mem;
	int          n_fail = 0, tests_run = 0;

	always #10 i_clk = ~i_clk;

	cst_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_dec(i_dec), .i_acc(i_acc),
		.i_ext_fetch_select(fsel), .i_code_data(cdat), .o_mem(o_mem),
		.o_psw(o_psw), .o_sp(o_sp), .o_b(o_b), .o_ir(o_ir), .o_op2(o_op2),
		.o_pc(o_pc), .o_state_num(o_state_num), .o_phase2(o_phase2),
		.o_instr_done(o_instr_done), .o_reg_addr(o_reg_addr),
		.o_ptr_addr(o_ptr_addr), .o_stack_addr(o_stack_addr),
		.o_sfr_sel(o_sfr_sel));
	cst_code_mem mem (.i_clk(i_clk), .i_mem(o_mem), .o_data(cdat));

	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [7:0] mf(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction

	// idle: reload pc each cycle so the model stays in step
	function automatic cst_dec_type pl(input logic [15:0] v);
		pl = '0;
		pl.pc_load = 1;
		pl.pc_val = v;
	endfunction

	function automatic cst_dec_type rnd();
		int t;
		rnd = '0;
		{rnd.two_byte, rnd.cy_we, rnd.cy, rnd.ac_we, rnd.ac, rnd.ov_we,
			rnd.ov, rnd.reg_idx, rnd.indirect, rnd.dir_addr} = 19'($urandom);
		t = $urandom % 3;
		rnd.push = t == 1;
		rnd.pop = t == 2;
		rnd.pc_load = $urandom % 8 == 0;
		rnd.pc_val = 16'($urandom);
	endfunction

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int t;
		logic rdy;
		@(posedge i_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1;
		t = 0;
		do begin
			@(posedge i_clk);
			{rdy, rd, er} = {o_pready, o_prdata, o_pslverr};
			t++;
		end while (rdy !== 1'b1 && t < 20);
		chk("pready", rdy, 1'b1);
		i_psel <= 0;
		i_penable <= 0;
		if (w && a == OFS_SP) esp = wd[7:0];
		if (w && a == OFS_PSW) epsw[7:1] = wd[7:1];
	endtask

	// lands in phase S1P1 of a fresh machine cycle
	task automatic sy();
		int t;
		t = 0;
		do begin
			@(negedge i_clk);
			t++;
		end while (o_instr_done !== 1'b1 && t < 60);
		@(negedge i_clk);
	endtask

	task automatic exe(input cst_dec_type d, input logic [7:0] a);
		int k, c, p;
		logic [15:0] pc0;
		logic x, x2;
		c = d.kind == KIND_MULDIV ? 4 : (d.two_cycle ? 2 : 1);
		x = d.kind == KIND_XMOVE;
		pc0 = epc;
		chk("code_int", o_mem.code_int, fsel && pc0 <= ROM_TOP);
		k = 0;
		while (1) begin
			p = k % 12;
			x2 = x && k >= 12;
			chk("state", {o_state_num, o_phase2}, {3'(p / 2 + 1), p[0]});
			chk("ale", o_mem.ale, p inside {1, 2} || p inside {7, 8} && !x2);
			chk("fetch", o_mem.code_rd, p inside {0, 1, 6, 7} && !x2);
			chk("xstb", o_mem.xdata_stb, x2 && p >= 3 && p <= 9);
			chk("done", o_instr_done, k == 12 * c - 1);
			if (k == 5) begin
				chk("reg", o_reg_addr, {3'b000, epsw[4:3], d.reg_idx});
				chk("sfr", o_sfr_sel, !d.indirect && d.dir_addr[7]);
				chk("ptr", o_ptr_addr, {3'b000, epsw[4:3], 2'b00, d.reg_idx[0]});
				chk("stack", o_stack_addr, d.push ? esp + 8'h01 : esp);
			end
			if (k >= 12 * c - 1 || k > 60) break;
			if (k == 0) begin
				@(posedge i_clk);
				i_dec <= d;
				i_acc <= a;
			end
			@(negedge i_clk);
			k++;
		end
		epc = d.pc_load ? d.pc_val : pc0 + 16'(1 + d.two_byte);
		if (d.cy_we) epsw[7] = d.cy;
		if (d.ac_we) epsw[6] = d.ac;
		if (d.ov_we) epsw[2] = d.ov;
		epsw[0] = ^a;
		esp = esp + 8'(d.push) - 8'(d.pop);
		if (d.b_we) eb = d.b_val;
		@(posedge i_clk);
		i_dec <= pl(epc);
		@(negedge i_clk);
		chk("ir", o_ir, mf(pc0));
		if (d.two_byte) chk("op2", o_op2, mf(pc0 + 16'h0001));
		chk("pc", o_pc, epc);
		chk("psw", o_psw, epsw);
		chk("sp", o_sp, esp);
		chk("b", o_b, eb);
	endtask

	initial begin
		#400000;
		n_fail++;
		summarize();
	end

	initial begin
		logic [31:0] r;
		logic e;
		cst_dec_type d;
		i_dec = pl(16'h0000);
		{epsw, esp, eb, epc} = {PSW_RESET, SP_RESET, B_RESET, PC_RESET};
		r = $urandom(32'h7a7a);
		repeat (12) @(posedge i_clk);
		i_rstn <= 1;
		apb(0, OFS_PSW, 0, r, e);
		chk("psw_rst", r, 32'h0000_0000);
		apb(0, OFS_SP, 0, r, e);
		chk("sp_rst", r, 32'h0000_0007);
		apb(0, 8'h00, 0, r, e);
		chk("slverr", e, 1'b1);
		$display("test reset done");
		for (int bk = 0; bk < 4; bk++) begin
			r = $urandom;
			apb(1, OFS_PSW, {r[31:5], bk[1:0], r[2:0]}, r, e);
			apb(0, OFS_PSW, 0, r, e);
			chk("psw_rd", r, {24'h00_0000, epsw});
			apb(1, OFS_SP, $urandom, r, e);
			apb(0, OFS_SP, 0, r, e);
			chk("sp_rd", r, {24'h00_0000, esp});
			apb(0, OFS_TIMING, 0, r, e);
			chk("timing_sel", {r[31:10], r[9]}, {22'h00_0000, 1'b1});
			sy();
			repeat (10) exe(rnd(), 8'($urandom));
			$display("test bank %0d done", bk);
		end
		d = '0;
		d.kind = KIND_MULDIV;
		d.b_we = 1;
		d.b_val = 8'h3c;
		exe(d, 8'h81);
		d = '0;
		d.two_cycle = 1;
		exe(d, 8'h07);
		d.kind = KIND_XMOVE;
		exe(d, 8'h10);
		exe(pl(16'h3fff), 8'h00);
		exe(pl(16'h4000), 8'h00);
		exe(pl(16'h0100), 8'h00);
		$display("test cycles done");
		@(posedge i_clk);
		fsel <= 0;
		sy();
		exe(pl(16'h0200), 8'h01);
		$display("test select done");
		summarize();
	end
endmodule
`default_nettype wire
